// >>> include/atc_map.vh
`ifndef ATC_MAP_VH
`define ATC_MAP_VH
// register offsets
`define ATC_REG_CTRL 8'h00
`define ATC_REG_STATUS 8'h04
`define ATC_REG_STROBE 8'h08
`define ATC_REG_IRQ_STAT 8'h0c
`define ATC_REG_IRQ_MASK 8'h10
`define ATC_REG_POST_LEN 8'h14
`define ATC_REG_CONV_CNT 8'h18
`define ATC_REG_DAC0 8'h1c
`define ATC_REG_DAC1 8'h20
// control fields
`define ATC_CTRL_ACQ_EN 0
`define ATC_CTRL_PRETRIG 1
`define ATC_CTRL_EXT_CONV 2
`define ATC_CTRL_SCAN_MODE 3
`define ATC_CTRL_POSTED 4
`define ATC_CTRL_EXT_UPD 5
`define ATC_CTRL_TMR_IRQ 6
`define ATC_CTRL_W 7
// interrupt event fields
`define ATC_EV_ARMED_TRIG 0
`define ATC_EV_POST_START 1
`define ATC_EV_ACQ_DONE 2
`define ATC_EV_CONV_DONE 3
`define ATC_EV_CONV_DROP 4
`define ATC_EV_TIMED 5
`define ATC_EV_W 6
// reset values
`define ATC_CTRL_RST 7'h00
`define ATC_MASK_RST 6'h00
`define ATC_POST_LEN_RST 16'h0000
// bus responses
`define ATC_RESP_OKAY 2'b00
`define ATC_RESP_SLVERR 2'b10
// timing
`define ATC_CLK_NS 5
`define ATC_STROBE_NS 500
`define ATC_SCAN_NS 100
`endif

// >>> hdl/atc_edge_sync.v
`timescale 1ns/1ps
`default_nettype none
module atc_edge_sync (
    input wire core_clk,
    input wire rst,
    input wire pin_n,
    output reg level_q,
    output reg fall_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // level moves only once stages two and three agree; fall fires once per edge
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            s1_q <= pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            fall_q <= (s2_q == s3_q) && !s3_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule // atc_edge_sync
`default_nettype wire

// >>> hdl/atc_pulse_gen.v
`timescale 1ns/1ps
`default_nettype none
module atc_pulse_gen #(
    parameter [15:0] CYCLES = 16'h0064,
    parameter [0:0] IDLE_LVL = 1'b1
) (
    input wire core_clk,
    input wire rst,
    input wire fire,
    output reg pulse_q
);
    reg [15:0] cnt_q;

    // active for CYCLES clocks after fire; a new fire restarts the count
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            pulse_q <= IDLE_LVL;
        end else if (fire) begin
            cnt_q <= CYCLES - 16'h0001;
            pulse_q <= ~IDLE_LVL;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end else begin
            pulse_q <= IDLE_LVL;
        end
    end
endmodule // atc_pulse_gen
`default_nettype wire

// >>> hdl/atc_trig_ctrl.v
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "atc_map.vh"
`default_nettype none
module atc_trig_ctrl #(
    parameter DAC_W = 16
) (
    input wire core_clk,
    input wire rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire acq_trigger_n,
    input wire conv_gate_n,
    input wire ext_convert_n,
    input wire dac_update_trigger_n,
    input wire int_convert,
    input wire adc_sample_taken,
    output reg adc_convert,
    output wire scan_pulse_out,
    output wire soft_strobe_n,
    output reg dac_update,
    output reg [DAC_W-1:0] dac0_value,
    output reg [DAC_W-1:0] dac1_value,
    output reg irq
);
    localparam integer STROBE_I = (`ATC_STROBE_NS + `ATC_CLK_NS - 1) / `ATC_CLK_NS;
    localparam integer SCAN_I = (`ATC_SCAN_NS + `ATC_CLK_NS - 1) / `ATC_CLK_NS;
    localparam [15:0] STROBE_CYC = STROBE_I[15:0];
    localparam [15:0] SCAN_CYC = SCAN_I[15:0];

    localparam [2:0] A_IDLE = 3'h0;
    localparam [2:0] A_ARMED = 3'h1;
    localparam [2:0] A_PRE = 3'h2;
    localparam [2:0] A_POST = 3'h3;
    localparam [2:0] A_DONE = 3'h4;

    localparam C_IDLE = 1'b0;
    localparam C_WAIT = 1'b1;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] val;
        input [3:0] strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            case (a)
                `ATC_REG_CTRL, `ATC_REG_STATUS, `ATC_REG_STROBE, `ATC_REG_IRQ_STAT,
                `ATC_REG_IRQ_MASK, `ATC_REG_POST_LEN, `ATC_REG_CONV_CNT,
                `ATC_REG_DAC0, `ATC_REG_DAC1: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // synchronised connector inputs
    wire trig_lvl;
    wire trig_fall;
    wire gate_lvl;
    wire conv_fall;
    wire tmr_fall;

    atc_edge_sync u_sync_trig (
        .core_clk(core_clk),
        .rst(rst),
        .pin_n(acq_trigger_n),
        .level_q(trig_lvl),
        .fall_q(trig_fall)
    );
    atc_edge_sync u_sync_gate (
        .core_clk(core_clk),
        .rst(rst),
        .pin_n(conv_gate_n),
        .level_q(gate_lvl),
        .fall_q()
    );
    atc_edge_sync u_sync_conv (
        .core_clk(core_clk),
        .rst(rst),
        .pin_n(ext_convert_n),
        .level_q(),
        .fall_q(conv_fall)
    );
    atc_edge_sync u_sync_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .pin_n(dac_update_trigger_n),
        .level_q(),
        .fall_q(tmr_fall)
    );

    // registers
    reg [`ATC_CTRL_W-1:0] ctrl_q;
    reg [`ATC_EV_W-1:0] irq_stat_q;
    reg [`ATC_EV_W-1:0] irq_stat_d;
    reg [`ATC_EV_W-1:0] irq_mask_q;
    reg [15:0] post_len_q;
    reg [15:0] conv_cnt_q;
    reg [15:0] post_cnt_q;
    reg [DAC_W-1:0] dac0_post_q;
    reg [DAC_W-1:0] dac1_post_q;
    reg [2:0] acq_q;
    reg [2:0] acq_d;
    reg conv_q;
    reg strobe_fire_q;
    reg scan_fire_q;

    // write channel state
    reg aw_full_q;
    reg w_full_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
    wire wr_ctrl = do_wr && (awaddr_q == `ATC_REG_CTRL);
    wire wr_strobe = do_wr && (awaddr_q == `ATC_REG_STROBE);
    wire wr_stat = do_wr && (awaddr_q == `ATC_REG_IRQ_STAT);
    wire wr_mask = do_wr && (awaddr_q == `ATC_REG_IRQ_MASK);
    wire wr_post = do_wr && (awaddr_q == `ATC_REG_POST_LEN);
    wire wr_dac0 = do_wr && (awaddr_q == `ATC_REG_DAC0);
    wire wr_dac1 = do_wr && (awaddr_q == `ATC_REG_DAC1);
    wire [31:0] ctrl_wr = merge({25'h0, ctrl_q}, wdata_q, wstrb_q);
    wire [31:0] post_wr = merge({16'h0, post_len_q}, wdata_q, wstrb_q);
    wire [31:0] stat_clr = merge(32'h0, wdata_q, wstrb_q);
    wire [31:0] dac0_wr = merge({{(32-DAC_W){1'b0}}, dac0_post_q}, wdata_q, wstrb_q);
    wire [31:0] dac1_wr = merge({{(32-DAC_W){1'b0}}, dac1_post_q}, wdata_q, wstrb_q);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ATC_RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // acquisition sequencer
    wire acq_active = (acq_q == A_PRE) || (acq_q == A_POST);
    wire post_last = (post_len_q != 16'h0000) && (post_cnt_q + 16'h0001 >= post_len_q);
    wire conv_end = (conv_q == C_WAIT) && adc_sample_taken;
    wire conv_src = ctrl_q[`ATC_CTRL_EXT_CONV] ? conv_fall : int_convert;
    wire conv_ok = acq_active && gate_lvl && (conv_q == C_IDLE);
    wire conv_start = conv_src && conv_ok;
    wire conv_drop = conv_src && !conv_ok;

    always @* begin
        acq_d = acq_q;
        case (acq_q)
            A_IDLE: begin
                if (ctrl_q[`ATC_CTRL_ACQ_EN]) begin
                    acq_d = A_ARMED;
                end
            end
            A_ARMED: begin
                if (trig_fall) begin
                    acq_d = ctrl_q[`ATC_CTRL_PRETRIG] ? A_PRE : A_POST;
                end
            end
            A_PRE: begin
                if (trig_fall) begin
                    acq_d = A_POST;
                end
            end
            A_POST: begin
                if (conv_end && post_last) begin
                    acq_d = A_DONE;
                end
            end
            A_DONE: acq_d = A_DONE;
            default: acq_d = A_IDLE;
        endcase
        if (!ctrl_q[`ATC_CTRL_ACQ_EN]) begin
            acq_d = A_IDLE;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acq_q <= A_IDLE;
            conv_q <= C_IDLE;
            adc_convert <= 1'b0;
            scan_fire_q <= 1'b0;
            conv_cnt_q <= 16'h0000;
            post_cnt_q <= 16'h0000;
        end else begin
            acq_q <= acq_d;
            adc_convert <= conv_start;
            scan_fire_q <= conv_end && ctrl_q[`ATC_CTRL_SCAN_MODE];
            case (conv_q)
                C_IDLE: begin
                    if (conv_start) begin
                        conv_q <= C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (adc_sample_taken) begin
                        conv_q <= C_IDLE;
                    end
                end
                default: conv_q <= C_IDLE;
            endcase
            if (acq_q == A_IDLE && acq_d == A_ARMED) begin
                conv_cnt_q <= 16'h0000;
            end else if (conv_end) begin
                conv_cnt_q <= conv_cnt_q + 16'h0001;
            end
            if (acq_q != A_POST) begin
                post_cnt_q <= 16'h0000;
            end else if (conv_end) begin
                post_cnt_q <= post_cnt_q + 16'h0001;
            end
        end
    end

    // control, output converters and strobe
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `ATC_CTRL_RST;
            irq_mask_q <= `ATC_MASK_RST;
            post_len_q <= `ATC_POST_LEN_RST;
            dac0_post_q <= {DAC_W{1'b0}};
            dac1_post_q <= {DAC_W{1'b0}};
            dac0_value <= {DAC_W{1'b0}};
            dac1_value <= {DAC_W{1'b0}};
            dac_update <= 1'b0;
            strobe_fire_q <= 1'b0;
        end else begin
            strobe_fire_q <= wr_strobe;
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr[`ATC_CTRL_W-1:0];
            end
            if (wr_mask) begin
                irq_mask_q <= wdata_q[`ATC_EV_W-1:0];
            end
            if (wr_post) begin
                post_len_q <= post_wr[15:0];
            end
            if (wr_dac0) begin
                dac0_post_q <= dac0_wr[DAC_W-1:0];
            end
            if (wr_dac1) begin
                dac1_post_q <= dac1_wr[DAC_W-1:0];
            end
            dac_update <= 1'b0;
            if (!ctrl_q[`ATC_CTRL_POSTED]) begin
                dac0_value <= dac0_post_q;
                dac1_value <= dac1_post_q;
            end else if (tmr_fall && ctrl_q[`ATC_CTRL_EXT_UPD]) begin
                dac0_value <= dac0_post_q;
                dac1_value <= dac1_post_q;
                dac_update <= 1'b1;
            end
        end
    end

    atc_pulse_gen #(
        .CYCLES(STROBE_CYC),
        .IDLE_LVL(1'b1)
    ) u_strobe (
        .core_clk(core_clk),
        .rst(rst),
        .fire(strobe_fire_q),
        .pulse_q(soft_strobe_n)
    );

    atc_pulse_gen #(
        .CYCLES(SCAN_CYC),
        .IDLE_LVL(1'b0)
    ) u_scan (
        .core_clk(core_clk),
        .rst(rst),
        .fire(scan_fire_q),
        .pulse_q(scan_pulse_out)
    );

    // sticky events, set wins over clear
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~stat_clr[`ATC_EV_W-1:0];
        end
        if (acq_q == A_ARMED && trig_fall) begin
            irq_stat_d[`ATC_EV_ARMED_TRIG] = 1'b1;
        end
        if (acq_q != A_POST && acq_d == A_POST) begin
            irq_stat_d[`ATC_EV_POST_START] = 1'b1;
        end
        if (acq_q == A_POST && acq_d == A_DONE) begin
            irq_stat_d[`ATC_EV_ACQ_DONE] = 1'b1;
        end
        if (conv_end) begin
            irq_stat_d[`ATC_EV_CONV_DONE] = 1'b1;
        end
        if (conv_drop) begin
            irq_stat_d[`ATC_EV_CONV_DROP] = 1'b1;
        end
        if (tmr_fall && ctrl_q[`ATC_CTRL_TMR_IRQ]) begin
            irq_stat_d[`ATC_EV_TIMED] = 1'b1;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= {`ATC_EV_W{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // read channel
    reg [31:0] rd_d;

    always @* begin
        case (s_axi_araddr)
            `ATC_REG_CTRL: rd_d = {25'h0, ctrl_q};
            `ATC_REG_STATUS: rd_d = {26'h0, trig_lvl, gate_lvl, conv_q, acq_q};
            `ATC_REG_IRQ_STAT: rd_d = {26'h0, irq_stat_q};
            `ATC_REG_IRQ_MASK: rd_d = {26'h0, irq_mask_q};
            `ATC_REG_POST_LEN: rd_d = {16'h0, post_len_q};
            `ATC_REG_CONV_CNT: rd_d = {16'h0, conv_cnt_q};
            `ATC_REG_DAC0: rd_d = {{(32-DAC_W){1'b0}}, dac0_post_q};
            `ATC_REG_DAC1: rd_d = {{(32-DAC_W){1'b0}}, dac1_post_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ATC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= mapped(s_axi_araddr) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // atc_trig_ctrl
`default_nettype wire

// >>> bench/atc_trig_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module atc_trig_ctrl_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_bvalid,
    input wire logic int_convert,
    input wire logic adc_sample_taken,
    input wire logic conv_gate_n,
    input wire logic ext_convert_n,
    input wire logic dac_update_trigger_n,
    input wire logic adc_convert,
    input wire logic scan_pulse_out,
    input wire logic soft_strobe_n,
    input wire logic dac_update
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] low_q;
    // strobe low-time counter, saturating
    always @(posedge core_clk or posedge rst) begin
        if (rst) low_q <= 8'h00;
        else if (!soft_strobe_n) low_q <= (low_q == 8'hff) ? low_q : low_q + 8'h01;
        else low_q <= 8'h00;
    end
    AST_STROBE_LEN: assert property ($rose(soft_strobe_n) |-> low_q >= 8'h64)
        else $error("strobe low pulse too short");
    AST_STROBE_CAUSE: assert property ($fell(soft_strobe_n) |->
        $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
        else $error("strobe fired without a register write");
    AST_SCAN_AFTER: assert property ($rose(scan_pulse_out) |->
        $past(adc_sample_taken, 2) || $past(adc_sample_taken, 3))
        else $error("scan pulse rose before sample was taken");
    AST_SCAN_WIDTH: assert property ($rose(scan_pulse_out) |-> scan_pulse_out [*8])
        else $error("scan pulse broken up");
    AST_CONV_PULSE: assert property (adc_convert |=> !adc_convert)
        else $error("convert pulse longer than one cycle");
    AST_CONV_CAUSE: assert property (adc_convert |-> $past(int_convert, 1) || $past(int_convert, 2)
        || !$past(ext_convert_n, 2) || !$past(ext_convert_n, 3))
        else $error("conversion without a request");
    AST_CONV_GATED: assert property ((!conv_gate_n) [*8] |-> !adc_convert)
        else $error("conversion while gate held low");
    AST_DAC_CAUSE: assert property (dac_update |-> !$past(dac_update_trigger_n, 2))
        else $error("converter update without timer trigger");
    AST_DAC_ONCE: assert property (dac_update |=> !dac_update)
        else $error("timer trigger acted on twice");
endmodule // atc_trig_ctrl_asserts
bind atc_trig_ctrl atc_trig_ctrl_asserts chk (.core_clk(core_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
    .int_convert(int_convert), .adc_sample_taken(adc_sample_taken), .conv_gate_n(conv_gate_n),
    .ext_convert_n(ext_convert_n), .dac_update_trigger_n(dac_update_trigger_n), .adc_convert(adc_convert),
    .scan_pulse_out(scan_pulse_out), .soft_strobe_n(soft_strobe_n), .dac_update(dac_update));
`default_nettype wire

// >>> bench/atc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module atc_far_end (
    input wire logic core_clk,
    input wire logic adc_convert,
    output logic acq_trigger_n,
    output logic conv_gate_n,
    output logic ext_convert_n,
    output logic dac_update_trigger_n,
    output logic adc_sample_taken
);
    int lat = 2;
    int cnt = 0;
    initial begin
        acq_trigger_n = 1'b1;
        conv_gate_n = 1'b1;
        ext_convert_n = 1'b1;
        dac_update_trigger_n = 1'b1;
        adc_sample_taken = 1'b0;
    end
    // converter holds the sample lat cycles after start
    always @(posedge core_clk) begin
        adc_sample_taken <= (cnt == 1);
        if (adc_convert) cnt <= lat;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // one falling edge, each level held well over two cycles
    task automatic strike(input int which);
        @(posedge core_clk);
        case (which)
            0: acq_trigger_n <= 1'b0;
            1: ext_convert_n <= 1'b0;
            default: dac_update_trigger_n <= 1'b0;
        endcase
        repeat (8) @(posedge core_clk);
        acq_trigger_n <= 1'b1;
        ext_convert_n <= 1'b1;
        dac_update_trigger_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic set_gate(input logic v);
        @(posedge core_clk);
        conv_gate_n <= v;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // atc_far_end
`default_nettype wire

// >>> bench/atc_trig_ctrl_bench.sv
`timescale 1ns/1ps
`include "atc_map.vh"
`default_nettype none
module atc_trig_ctrl_bench;
    logic core_clk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, int_convert = 1'b0;
    logic awready, wready, arready, bvalid, rvalid, adc_convert, scan_pulse_out, soft_strobe_n, dac_update, irq;
    logic [1:0] bresp, rresp;
    logic [15:0] dac0_value, dac1_value;
    logic acq_trigger_n, conv_gate_n, ext_convert_n, dac_update_trigger_n, adc_sample_taken;
    logic [31:0] rd;
    logic [1:0] rs;
    int num_errors = 0, n_tests = 0, scans = 0, upd = 0, s0, w;
    always #2.5 core_clk = ~core_clk;
    atc_trig_ctrl uut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(s_axi_rready), .acq_trigger_n(acq_trigger_n), .conv_gate_n(conv_gate_n),
        .ext_convert_n(ext_convert_n), .dac_update_trigger_n(dac_update_trigger_n),
        .int_convert(int_convert), .adc_sample_taken(adc_sample_taken),
        .adc_convert(adc_convert), .scan_pulse_out(scan_pulse_out), .soft_strobe_n(soft_strobe_n),
        .dac_update(dac_update), .dac0_value(dac0_value), .dac1_value(dac1_value), .irq(irq));
    atc_far_end far (.core_clk(core_clk), .adc_convert(adc_convert), .acq_trigger_n(acq_trigger_n),
        .conv_gate_n(conv_gate_n), .ext_convert_n(ext_convert_n), .dac_update_trigger_n(dac_update_trigger_n),
        .adc_sample_taken(adc_sample_taken));
    logic scan_d = 1'b0;
    always @(posedge core_clk) begin
        if (scan_pulse_out && !scan_d) scans++;
        if (dac_update) upd++;
        scan_d <= scan_pulse_out;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, wd;
        int t;
        aw = 1'b1;
        wd = 1'b1;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (aw && awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
            if (wd && wready) begin wd = 1'b0; s_axi_wvalid <= 1'b0; end
        end while (!(bvalid && !aw && !wd) && t < 100);
        if (t >= 100) num_errors++;
        check({30'h0, bresp}, 32'h0);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar;
        int t;
        ar = 1'b1;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (ar && arready) begin ar = 1'b0; s_axi_arvalid <= 1'b0; end
        end while (!(rvalid && !ar) && t < 100);
        if (t >= 100) num_errors++;
        rd = s_axi_rdata;
        rs = rresp;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    initial begin
        #300000;
        num_errors++;
        complete_run;
    end
    initial begin
        idle(4);
        rst <= 1'b0;
        idle(1);
        axi_rd(`ATC_REG_CTRL); check(rd, 32'h0);
        axi_rd(`ATC_REG_IRQ_MASK); check(rd, 32'h0);
        axi_rd(8'h40); check({rd[31:2], rs}, 32'h2);
        check({31'h0, soft_strobe_n}, 32'h1);
        axi_wr(`ATC_REG_STROBE, 32'h1);
        w = 0;
        while (soft_strobe_n === 1'b1 && w < 20) begin idle(1); w++; end
        w = 0;
        while (soft_strobe_n === 1'b0 && w < 300) begin idle(1); w++; end
        check(w >= 100, 1);
        $display("reset and strobe test done");
        axi_wr(`ATC_REG_IRQ_MASK, 32'h3f);
        axi_wr(`ATC_REG_POST_LEN, 32'h2);
        axi_wr(`ATC_REG_CTRL, 32'h0d);
        axi_rd(`ATC_REG_STATUS); check(rd[2:0], 3'h1);
        far.strike(0);
        axi_rd(`ATC_REG_STATUS); check(rd[2:0], 3'h3);
        s0 = scans;
        far.lat = 2;
        far.strike(1);
        far.lat = 30;
        far.strike(1);
        idle(60);
        axi_rd(`ATC_REG_CONV_CNT); check(rd, 32'h2);
        check(scans - s0, 2);
        axi_rd(`ATC_REG_STATUS); check(rd[2:0], 3'h4);
        far.strike(1);
        idle(40);
        axi_rd(`ATC_REG_CONV_CNT); check(rd, 32'h2);
        axi_rd(`ATC_REG_IRQ_STAT); check(rd[4], 1'b1);
        check({31'h0, irq}, 32'h1);
        axi_wr(`ATC_REG_IRQ_STAT, 32'h3f);
        idle(3);
        check({31'h0, irq}, 32'h0);
        $display("posttrigger test done");
        axi_wr(`ATC_REG_CTRL, 32'h0);
        axi_wr(`ATC_REG_CTRL, 32'h0f);
        far.strike(0);
        axi_rd(`ATC_REG_STATUS); check(rd[2:0], 3'h2);
        far.set_gate(1'b0);
        far.strike(1);
        idle(40);
        axi_rd(`ATC_REG_CONV_CNT); check(rd, 32'h0);
        far.set_gate(1'b1);
        far.strike(1);
        idle(40);
        axi_rd(`ATC_REG_CONV_CNT); check(rd, 32'h1);
        far.strike(0);
        axi_rd(`ATC_REG_STATUS); check(rd[2:0], 3'h3);
        axi_wr(`ATC_REG_CTRL, 32'h0b);
        int_convert <= 1'b1;
        idle(1);
        int_convert <= 1'b0;
        idle(40);
        axi_rd(`ATC_REG_CONV_CNT); check(rd, 32'h2);
        $display("pretrigger test done");
        axi_wr(`ATC_REG_CTRL, 32'h70);
        axi_wr(`ATC_REG_IRQ_MASK, 32'h0);
        axi_wr(`ATC_REG_IRQ_STAT, 32'h3f);
        axi_wr(`ATC_REG_DAC0, 32'h1234);
        axi_wr(`ATC_REG_DAC1, 32'habcd);
        idle(3);
        check({dac1_value, dac0_value}, 32'h0);
        far.strike(2);
        check({dac1_value, dac0_value}, 32'habcd1234);
        check(upd, 1);
        axi_rd(`ATC_REG_IRQ_STAT); check(rd[5], 1'b1);
        check({31'h0, irq}, 32'h0);
        axi_wr(`ATC_REG_IRQ_MASK, 32'h20);
        idle(3);
        check({31'h0, irq}, 32'h1);
        axi_wr(`ATC_REG_IRQ_STAT, 32'h20);
        idle(3);
        check({31'h0, irq}, 32'h0);
        s_axi_wstrb <= 4'h1;
        axi_wr(`ATC_REG_POST_LEN, 32'h0705);
        s_axi_wstrb <= 4'hf;
        axi_rd(`ATC_REG_POST_LEN); check(rd, 32'h5);
        $display("timer trigger test done");
        complete_run;
    end
endmodule // atc_trig_ctrl_bench
`default_nettype wire
